// [inc/scl_defines.svh]
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

// Register offsets
`define SCL_OFS_PORT_PTR 8'h1e
`define SCL_OFS_CAP_OVR 8'h20
`define SCL_OFS_REMOTE_ADDR 8'h4e
`define SCL_OFS_ID_SRC 8'h4f
`define SCL_OFS_BRIDGE_CFG 8'h54
`define SCL_OFS_PAIR_CTL 8'h5b
`define SCL_OFS_STATUS 8'h5c

// Reset values, port 1 pointer select and fast control capability value
`define SCL_RST_PORT_PTR 8'h01
`define SCL_RST_REMOTE_ADDR 8'ha0
`define SCL_RST_ZERO 8'h00
`define SCL_PORT1_SEL 8'h02
`define SCL_CAP_FAST_CTL 8'h8f

// Field positions and pairing mode codes
`define SCL_BIT_ID_SRC 0
`define SCL_BIT_AUX_AUDIO 1
`define SCL_BIT_REM_COPY 5
`define SCL_BIT_EXTERNAL_CONTROLLER_STRAP 7
`define SCL_BIT_CABLE 7
`define SCL_PAIR_MODE_HI 2
`define SCL_PAIR_FORCE_DUAL 3'h3
`define SCL_PAIR_FORCE_SINGLE 3'h4

// Strap decode bit positions within a level code
`define SCL_S0_ID_SRC 1
`define SCL_S0_AUX 0
`define SCL_S1_EXT 2
`define SCL_S1_CABLE 1
`define SCL_S1_REM_COPY 0

// Divider ratio in 1/255 steps; thresholds sit midway between nominal levels
`define SCL_S0_THRESH {8'h9c, 8'h61, 8'h1b}
`define SCL_S1_THRESH {8'he4, 8'hba, 8'h9c, 8'h7f, 8'h61, 8'h44, 8'h1b}

// Pixel clock limits in MHz
`define SCL_SINGLE_MAX_MHZ 8'd96
`define SCL_LEGACY_MAX_MHZ 8'd85
`define SCL_DUAL_MAX_MHZ 8'd210

`endif

// [inc/scl_pkg.sv]
package scl_pkg;
	typedef enum logic [1:0] {
		SCL_ST_WAIT = 2'b00,
		SCL_ST_CAPTURE = 2'b01,
		SCL_ST_RUN = 2'b10
	} scl_state_type;

	typedef enum logic [1:0] {
		SCL_ID_INTERNAL = 2'b00,
		SCL_ID_REMOTE = 2'b01,
		SCL_ID_LOCAL = 2'b10
	} scl_id_src_type;
endpackage

// [logic/scl_level_quant.sv]
module scl_level_quant #(
	parameter int LEVELS = 4,
	parameter int CODE_W = 2
) (
	input wire logic [7:0] ratio_i,
	input wire logic [LEVELS-2:0][7:0] thresh_i,
	output logic [CODE_W-1:0] level_o
);
	// Level index is the number of thresholds at or below the ratio
	always_comb begin
		level_o = '0;
		for (int i = 0; i < LEVELS - 1; i++) begin
			if (ratio_i >= thresh_i[i]) begin
				level_o = CODE_W'(i + 1);
			end
		end
	end
endmodule

// [logic/scl_strap_link.sv]
// Contract
// (R1) Settings come from straps or later register writes; writes override straps.
// (R2) Both straps sampled at power-up into their register fields.
// (R3) Strap 0 quantized to four levels, strap 1 to eight, binary order.
// (R4) Source 0: remote id memory if present, else internal SRAM.
// (R5) Remote id address defaults to 0xA0 and is writable.
// (R6) Source 1: external local id memory is used.
// (R7) Aux audio 0: link audio only; 1: adds aux serial audio.
// (R8) External control 0: internal; 1: external controller over control pins.
// (R9) Cable 0: twisted pair; 1: coaxial.
// (R10) Remote copy 1: copy remote image into SRAM if present.
// (R11) Latched straps readable/writable at 0x4F[0], 0x54[1,5,7], 0x5B[7].
// (R12) Single-link sends all video on one link, up to 96 MHz.
// (R13) Older receivers supported in single-link only below 85 MHz.
// (R14) Forced single mode disables secondary phy and its back channel.
// (R15) Dual-link alternates pixels on two lanes at half rate, up to 210 MHz.
// (R16) Auto dual only with dual-capable receiver and sufficient clock, unless forced.
// (R17) Secondary link may carry fast control channel if receiver supports it.
// (R18) Host sets pointer 0x02, writes 0x8F capability, restores pointer 0x01.
// (R19) Writing 011b to pairing control low bits forces dual, no auto-detect.
// (R20) Host performs all configuration writes in the initial sequence.
// (R21) Straps sampled once after reset release, never again.
`include "scl_defines.svh"

module scl_strap_link
	import scl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] strap0_ratio_i,
	input wire logic [7:0] strap1_ratio_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic remote_id_present_i,
	input wire logic dual_capable_rx_i,
	input wire logic pclk_min_met_i,
	input wire logic [7:0] pclk_mhz_i,
	input wire logic pix_valid_i,
	input wire logic [23:0] pix_data_i,
	output logic [1:0] id_source_o,
	output logic [7:0] remote_id_addr_o,
	output logic id_copy_req_o,
	output logic aux_audio_en_o,
	output logic ext_ctrl_o,
	output logic cable_type_bit_o,
	output logic dual_mode_o,
	output logic secondary_en_o,
	output logic fast_control_channel_o,
	output logic rate_over_o,
	output logic legacy_ok_o,
	output logic lane0_valid_o,
	output logic [23:0] lane0_data_o,
	output logic lane1_valid_o,
	output logic [23:0] lane1_data_o
);
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;
	logic [1:0] s0_level;
	logic [2:0] s1_level;
	scl_level_quant #(.LEVELS(4), .CODE_W(2)) u_q0 ( // see (R3)
		.ratio_i(strap0_ratio_i),
		.thresh_i(`SCL_S0_THRESH),
		.level_o(s0_level)
	);
	scl_level_quant #(.LEVELS(8), .CODE_W(3)) u_q1 ( // see (R3)
		.ratio_i(strap1_ratio_i),
		.thresh_i(`SCL_S1_THRESH),
		.level_o(s1_level)
	);
	scl_state_type state_reg, state_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] cap0_reg, cap0_next;
	logic [7:0] cap1_reg, cap1_next;
	logic [7:0] raddr_reg, raddr_next;
	logic [7:0] idsrc_reg, idsrc_next;
	logic [7:0] bcfg_reg, bcfg_next;
	logic [7:0] pair_reg, pair_next;
	logic [7:0] rdata_reg, rdata_next;
	logic wr_ok;
	assign wr_ok = reg_wr_i && (state_reg == SCL_ST_RUN);
	always_comb begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		cap0_next = cap0_reg;
		cap1_next = cap1_reg;
		raddr_next = raddr_reg;
		idsrc_next = idsrc_reg;
		bcfg_next = bcfg_reg;
		pair_next = pair_reg;
		case (state_reg)
			SCL_ST_WAIT: state_next = SCL_ST_CAPTURE;
			SCL_ST_CAPTURE: begin
				// One-shot latch of both straps
				idsrc_next[`SCL_BIT_ID_SRC] = s0_level[`SCL_S0_ID_SRC]; // see (R2)
				bcfg_next[`SCL_BIT_AUX_AUDIO] = s0_level[`SCL_S0_AUX]; // see (R2)
				bcfg_next[`SCL_BIT_EXTERNAL_CONTROLLER_STRAP] = s1_level[`SCL_S1_EXT]; // see (R2)
				bcfg_next[`SCL_BIT_REM_COPY] = s1_level[`SCL_S1_REM_COPY]; // see (R2)
				pair_next[`SCL_BIT_CABLE] = s1_level[`SCL_S1_CABLE]; // see (R2)
				state_next = SCL_ST_RUN; // see (R21)
			end
			SCL_ST_RUN: state_next = SCL_ST_RUN; // see (R21)
			default: state_next = SCL_ST_WAIT;
		endcase
		if (wr_ok) begin
			case (reg_addr_i) // see (R1) (R11)
				`SCL_OFS_PORT_PTR: ptr_next = reg_wdata_i;
				`SCL_OFS_CAP_OVR: begin
					// Pointer picks which downstream port the override belongs to
					if (ptr_reg == `SCL_PORT1_SEL) begin // see (R18)
						cap1_next = reg_wdata_i;
					end else begin
						cap0_next = reg_wdata_i;
					end
				end
				`SCL_OFS_REMOTE_ADDR: raddr_next = reg_wdata_i; // see (R5)
				`SCL_OFS_ID_SRC: idsrc_next = reg_wdata_i;
				`SCL_OFS_BRIDGE_CFG: bcfg_next = reg_wdata_i;
				`SCL_OFS_PAIR_CTL: pair_next = reg_wdata_i; // see (R19)
				default: ;
			endcase
		end
	end

	logic force_dual, force_single, dual_mode, sec_en, fcc_ok;
	logic [7:0] status;
	always_comb begin
		force_dual = pair_reg[`SCL_PAIR_MODE_HI:0] == `SCL_PAIR_FORCE_DUAL; // see (R19)
		force_single = pair_reg[`SCL_PAIR_MODE_HI:0] == `SCL_PAIR_FORCE_SINGLE;
		// Forced modes bypass auto-detection entirely
		if (force_dual) begin
			dual_mode = 1'b1; // see (R19)
		end else if (force_single) begin
			dual_mode = 1'b0;
		end else begin
			dual_mode = dual_capable_rx_i && pclk_min_met_i; // see (R16)
		end
		sec_en = !force_single; // see (R14)
		fcc_ok = sec_en && (dual_capable_rx_i || cap1_reg == `SCL_CAP_FAST_CTL); // see (R17)
		status = {4'h0, fcc_ok, sec_en, dual_mode, state_reg == SCL_ST_RUN};
		rdata_next = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`SCL_OFS_PORT_PTR: rdata_next = ptr_reg;
				`SCL_OFS_CAP_OVR: rdata_next = (ptr_reg == `SCL_PORT1_SEL) ? cap1_reg : cap0_reg;
				`SCL_OFS_REMOTE_ADDR: rdata_next = raddr_reg;
				`SCL_OFS_ID_SRC: rdata_next = idsrc_reg; // see (R11)
				`SCL_OFS_BRIDGE_CFG: rdata_next = bcfg_reg; // see (R11)
				`SCL_OFS_PAIR_CTL: rdata_next = pair_reg; // see (R11)
				`SCL_OFS_STATUS: rdata_next = status;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SCL_ST_WAIT;
			ptr_reg <= `SCL_RST_PORT_PTR;
			cap0_reg <= `SCL_RST_ZERO;
			cap1_reg <= `SCL_RST_ZERO;
			raddr_reg <= `SCL_RST_REMOTE_ADDR;
			idsrc_reg <= `SCL_RST_ZERO;
			bcfg_reg <= `SCL_RST_ZERO;
			pair_reg <= `SCL_RST_ZERO;
			rdata_reg <= `SCL_RST_ZERO;
		end else begin
			state_reg <= state_next;
			ptr_reg <= ptr_next;
			cap0_reg <= cap0_next;
			cap1_reg <= cap1_next;
			raddr_reg <= raddr_next;
			idsrc_reg <= idsrc_next;
			bcfg_reg <= bcfg_next;
			pair_reg <= pair_next;
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata_o = rdata_reg;
	// Setting outputs, registered
	logic [1:0] idsel_reg, idsel_next;
	logic copy_reg, copy_next;
	logic [7:0] cfg_out_reg, cfg_out_next;
	logic [7:0] pclk_lim;
	always_comb begin
		if (idsrc_reg[`SCL_BIT_ID_SRC]) begin
			idsel_next = SCL_ID_LOCAL; // see (R6)
		end else if (remote_id_present_i) begin
			idsel_next = SCL_ID_REMOTE; // see (R4)
		end else begin
			idsel_next = SCL_ID_INTERNAL; // see (R4)
		end
		copy_next = bcfg_reg[`SCL_BIT_REM_COPY] && remote_id_present_i; // see (R10)
		pclk_lim = dual_mode ? `SCL_DUAL_MAX_MHZ : `SCL_SINGLE_MAX_MHZ; // see (R12) (R15)
		cfg_out_next = {
			pclk_mhz_i > pclk_lim,
			!dual_mode && pclk_mhz_i < `SCL_LEGACY_MAX_MHZ, // see (R13)
			fcc_ok,
			sec_en,
			dual_mode,
			pair_reg[`SCL_BIT_CABLE], // see (R9)
			bcfg_reg[`SCL_BIT_EXTERNAL_CONTROLLER_STRAP], // see (R8)
			bcfg_reg[`SCL_BIT_AUX_AUDIO] // see (R7)
		};
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			idsel_reg <= SCL_ID_INTERNAL;
			copy_reg <= 1'b0;
			cfg_out_reg <= `SCL_RST_ZERO;
		end else begin
			idsel_reg <= idsel_next;
			copy_reg <= copy_next;
			cfg_out_reg <= cfg_out_next;
		end
	end
	assign id_source_o = idsel_reg;
	assign remote_id_addr_o = raddr_reg;
	assign id_copy_req_o = copy_reg;
	assign aux_audio_en_o = cfg_out_reg[0];
	assign ext_ctrl_o = cfg_out_reg[1];
	assign cable_type_bit_o = cfg_out_reg[2];
	assign dual_mode_o = cfg_out_reg[3];
	assign secondary_en_o = cfg_out_reg[4];
	assign fast_control_channel_o = cfg_out_reg[5];
	assign legacy_ok_o = cfg_out_reg[6];
	assign rate_over_o = cfg_out_reg[7];

	// Pixel steering: single puts all on lane 0, dual alternates lanes
	logic odd_reg, odd_next;
	logic v0_reg, v0_next, v1_reg, v1_next;
	logic [23:0] d0_reg, d0_next, d1_reg, d1_next;
	always_comb begin
		odd_next = odd_reg;
		v0_next = 1'b0;
		v1_next = 1'b0;
		d0_next = d0_reg;
		d1_next = d1_reg;
		if (!cfg_out_reg[3]) begin
			odd_next = 1'b0;
			if (pix_valid_i) begin
				v0_next = 1'b1; // see (R12)
				d0_next = pix_data_i;
			end
		end else if (pix_valid_i) begin
			odd_next = !odd_reg; // see (R15)
			if (odd_reg) begin
				v1_next = 1'b1;
				d1_next = pix_data_i;
			end else begin
				v0_next = 1'b1;
				d0_next = pix_data_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			odd_reg <= 1'b0;
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
			d0_reg <= 24'h000000;
			d1_reg <= 24'h000000;
		end else begin
			odd_reg <= odd_next;
			v0_reg <= v0_next;
			v1_reg <= v1_next;
			d0_reg <= d0_next;
			d1_reg <= d1_next;
		end
	end
	assign lane0_valid_o = v0_reg;
	assign lane0_data_o = d0_reg;
	assign lane1_valid_o = v1_reg;
	assign lane1_data_o = d1_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);
	strap_once_a: assert property ( // see (R21)
		state_reg == SCL_ST_RUN |=> state_reg == SCL_ST_RUN)
		else $error("strap capture state left run");
	strap_latch_a: assert property ( // see (R2)
		state_reg == SCL_ST_CAPTURE && !reg_wr_i |=>
			pair_reg[`SCL_BIT_CABLE] == $past(s1_level[`SCL_S1_CABLE])
			&& idsrc_reg[`SCL_BIT_ID_SRC] == $past(s0_level[`SCL_S0_ID_SRC]))
		else $error("strap value not latched");
	write_override_a: assert property ( // see (R1)
		wr_ok && reg_addr_i == `SCL_OFS_BRIDGE_CFG |=> bcfg_reg == $past(reg_wdata_i))
		else $error("register write did not override strap");
	force_dual_a: assert property ( // see (R19)
		pair_reg[`SCL_PAIR_MODE_HI:0] == `SCL_PAIR_FORCE_DUAL |=> dual_mode_o)
		else $error("forced dual not applied");
	force_single_a: assert property ( // see (R14)
		pair_reg[`SCL_PAIR_MODE_HI:0] == `SCL_PAIR_FORCE_SINGLE |=> !secondary_en_o && !dual_mode_o)
		else $error("forced single left secondary on");
	auto_dual_a: assert property ( // see (R16)
		!force_dual && !(dual_capable_rx_i && pclk_min_met_i) |=> !dual_mode_o)
		else $error("auto dual without capable receiver");
	id_local_a: assert property ( // see (R6)
		idsrc_reg[`SCL_BIT_ID_SRC] |=> id_source_o == SCL_ID_LOCAL)
		else $error("local id source not selected");
	id_fallback_a: assert property ( // see (R4)
		!idsrc_reg[`SCL_BIT_ID_SRC] && !remote_id_present_i |=> id_source_o == SCL_ID_INTERNAL)
		else $error("no fallback to internal id");
	lane_alt_a: assert property ( // see (R15)
		lane0_valid_o && cfg_out_reg[3] && $past(cfg_out_reg[3]) && pix_valid_i |=> lane1_valid_o)
		else $error("dual pixel after lane 0 not sent on lane 1");
	single_lane_a: assert property ( // see (R12)
		!cfg_out_reg[3] && pix_valid_i |=> lane0_valid_o && lane0_data_o == $past(pix_data_i))
		else $error("single link pixel lost");
	port_sel_a: assert property ( // see (R18)
		wr_ok && reg_addr_i == `SCL_OFS_CAP_OVR && ptr_reg == `SCL_PORT1_SEL
			|=> cap1_reg == $past(reg_wdata_i))
		else $error("port 1 capability not written");

	cov_capture_c: cover property (state_reg == SCL_ST_CAPTURE ##1 state_reg == SCL_ST_RUN);
	cov_dual_c: cover property (lane0_valid_o ##1 lane1_valid_o);
	cov_fcc_c: cover property (fast_control_channel_o && dual_mode_o);
	cov_single_c: cover property (pair_reg[2:0] == `SCL_PAIR_FORCE_SINGLE ##1 !secondary_en_o);
endmodule

// [tb/scl_rx_model.sv]
module scl_rx_model (
	input wire logic clk_i,
	input wire logic lane0_valid_i,
	input wire logic [23:0] lane0_data_i,
	input wire logic lane1_valid_i,
	input wire logic [23:0] lane1_data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Arrival order of pixels, lane number in msb
	logic [24:0] got[$];
	always @(posedge clk_i) begin
		if (lane0_valid_i) begin
			got.push_back({1'b0, lane0_data_i});
		end
		if (lane1_valid_i) begin
			got.push_back({1'b1, lane1_data_i});
		end
	end
endmodule

// [tb/scl_strap_link_tb.sv]
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end

module scl_strap_link_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] LVL[8] = '{8'h00, 8'h35, 8'h52, 8'h70, 8'h8d, 8'haa, 8'hc9, 8'hff};
	localparam int S0_IDX[4] = '{0, 1, 4, 5};
	int err_count = 0;
	int n_tests = 0;
	logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, remote_id_present_i, dual_capable_rx_i;
	logic pclk_min_met_i, pix_valid_i;
	logic [7:0] strap0_ratio_i, strap1_ratio_i, reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [7:0] pclk_mhz_i, remote_id_addr_o;
	logic [23:0] pix_data_i, lane0_data_o, lane1_data_o;
	logic [1:0] id_source_o;
	logic id_copy_req_o, aux_audio_en_o, ext_ctrl_o, cable_type_bit_o, dual_mode_o;
	logic secondary_en_o, fast_control_channel_o, rate_over_o, legacy_ok_o;
	logic lane0_valid_o, lane1_valid_o;

	scl_strap_link i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .strap0_ratio_i(strap0_ratio_i),
		.strap1_ratio_i(strap1_ratio_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.remote_id_present_i(remote_id_present_i), .dual_capable_rx_i(dual_capable_rx_i),
		.pclk_min_met_i(pclk_min_met_i), .pclk_mhz_i(pclk_mhz_i), .pix_valid_i(pix_valid_i),
		.pix_data_i(pix_data_i), .id_source_o(id_source_o), .remote_id_addr_o(remote_id_addr_o),
		.id_copy_req_o(id_copy_req_o), .aux_audio_en_o(aux_audio_en_o), .ext_ctrl_o(ext_ctrl_o),
		.cable_type_bit_o(cable_type_bit_o), .dual_mode_o(dual_mode_o), .secondary_en_o(secondary_en_o),
		.fast_control_channel_o(fast_control_channel_o), .rate_over_o(rate_over_o),
		.legacy_ok_o(legacy_ok_o), .lane0_valid_o(lane0_valid_o), .lane0_data_o(lane0_data_o),
		.lane1_valid_o(lane1_valid_o), .lane1_data_o(lane1_data_o));

	scl_rx_model i_rx (.clk_i(clk_i), .lane0_valid_i(lane0_valid_o), .lane0_data_i(lane0_data_o),
		.lane1_valid_i(lane1_valid_o), .lane1_data_i(lane1_data_o));

	always #4 clk_i = ~clk_i;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK(reg_rdata_o, exp)
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
	endtask

	task automatic send_px(input int n, input logic dual);
		i_rx.got.delete();
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i);
			pix_valid_i <= 1'b1;
			pix_data_i <= 24'h100 + 24'(k);
		end
		@(posedge clk_i);
		pix_valid_i <= 1'b0;
		settle();
		`CHK(i_rx.got.size(), n)
		for (int k = 0; k < i_rx.got.size(); k++) begin
			`CHK(i_rx.got[k], {dual & k[0], 24'h100 + 24'(k)})
		end
	endtask

	task automatic t_straps();
		logic [2:0] i3;
		logic [1:0] j2;
		for (int i = 0; i < 8; i++) begin
			i3 = 3'(i);
			j2 = i3[1:0];
			@(posedge clk_i);
			strap1_ratio_i <= LVL[i];
			strap0_ratio_i <= LVL[S0_IDX[j2]];
			do_reset();
			rdck(8'h54, {i3[2], 1'b0, i3[0], 3'h0, j2[0], 1'b0});
			rdck(8'h5b, {i3[1], 7'h00});
			rdck(8'h4f, {7'h00, j2[1]});
			`CHK(id_source_o, j2[1] ? 2'h2 : 2'h1)
			`CHK(id_copy_req_o, i3[0])
			`CHK({ext_ctrl_o, cable_type_bit_o, aux_audio_en_o}, {i3[2:1], j2[0]})
		end
		@(posedge clk_i);
		strap0_ratio_i <= 8'h00;
		strap1_ratio_i <= 8'h00;
		settle();
		rdck(8'h54, 8'ha2);
		rdck(8'h1e, 8'h01);
		rdck(8'h4e, 8'ha0);
	endtask

	task automatic t_override();
		wr(8'h4f, 8'h00);
		wr(8'h54, 8'h00);
		wr(8'h5b, 8'h00);
		wr(8'h4e, 8'h50);
		settle();
		`CHK(id_source_o, 2'h1)
		`CHK({ext_ctrl_o, cable_type_bit_o, aux_audio_en_o, id_copy_req_o}, 4'h0)
		`CHK(remote_id_addr_o, 8'h50)
		@(posedge clk_i);
		remote_id_present_i <= 1'b0;
		wr(8'h54, 8'h22);
		settle();
		`CHK(id_source_o, 2'h0)
		`CHK({aux_audio_en_o, id_copy_req_o}, 2'b10)
		rdck(8'h54, 8'h22);
		rdck(8'h77, 8'h00);
	endtask

	task automatic t_fast();
		`CHK(fast_control_channel_o, 1'b0)
		wr(8'h1e, 8'h02);
		wr(8'h20, 8'h8f);
		rdck(8'h20, 8'h8f);
		wr(8'h1e, 8'h01);
		settle();
		`CHK(fast_control_channel_o, 1'b1)
		rdck(8'h1e, 8'h01);
		rdck(8'h20, 8'h00);
	endtask

	task automatic t_modes();
		wr(8'h5b, 8'h03);
		pclk_mhz_i <= 8'd210;
		settle();
		`CHK({dual_mode_o, rate_over_o, secondary_en_o}, 3'b101)
		rdck(8'h5c, 8'h0f);
		send_px(5, 1'b1);
		@(posedge clk_i);
		pclk_mhz_i <= 8'd211;
		settle();
		`CHK(rate_over_o, 1'b1)
		wr(8'h5b, 8'h04);
		pclk_mhz_i <= 8'd85;
		settle();
		`CHK({dual_mode_o, secondary_en_o, fast_control_channel_o}, 3'h0)
		`CHK({rate_over_o, legacy_ok_o}, 2'b00)
		send_px(3, 1'b0);
		@(posedge clk_i);
		pclk_mhz_i <= 8'd84;
		settle();
		`CHK(legacy_ok_o, 1'b1)
		@(posedge clk_i);
		pclk_mhz_i <= 8'd97;
		settle();
		`CHK(rate_over_o, 1'b1)
		wr(8'h5b, 8'h00);
		dual_capable_rx_i <= 1'b1;
		pclk_min_met_i <= 1'b1;
		settle();
		`CHK(dual_mode_o, 1'b1)
		@(posedge clk_i);
		pclk_min_met_i <= 1'b0;
		settle();
		`CHK(dual_mode_o, 1'b0)
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		strap0_ratio_i = 8'h00;
		strap1_ratio_i = 8'h00;
		remote_id_present_i = 1'b1;
		dual_capable_rx_i = 1'b0;
		pclk_min_met_i = 1'b0;
		pclk_mhz_i = 8'd60;
		pix_valid_i = 1'b0;
		pix_data_i = 24'h000000;
		t_straps();
		t_override();
		t_fast();
		t_modes();
		report_and_stop();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#50000;
		err_count++;
		report_and_stop();
	end
endmodule
